/* hw/sfb_top.sv */
// sfb_top: command sequencer for an external serial NOR flash
// assumes rst_n synchronous to core_clk and a free-running link_clk
`timescale 1ns/10ps
`default_nettype none
`include "sfb_defs.svh"
module sfb_top #(
	parameter int LINK_KHZ = `SFB_LINK_KHZ,
	parameter int SCK_HALF = `SFB_SCK_HALF,
	parameter int FIFO_DEPTH = `SFB_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sfb_pkg::sfb_op_t cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic [15:0] cmd_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output logic busy,
	output logic boot_done,
	output logic [7:0] flash_status,
	output logic flash_serial_clock,
	output logic flash_serial_clock_oe,
	output logic flash_serial_out,
	output logic flash_serial_out_oe,
	output logic flash_select_primary_n,
	output logic flash_select_primary_oe,
	output logic flash_select_secondary_n,
	input wire logic flash_serial_in
);
	import sfb_pkg::*;
	localparam int SCK_KHZ = LINK_KHZ / (2 * SCK_HALF);
	localparam logic [3:0] GAP = 4'(`SFB_CS_GAP_CYC);
	localparam sfb_core_t CORE_RST = '{
		st: S_WRITE_ENABLE_INSTR, kind: K_WRITE_ENABLE_INSTR, op: OP_READ, boot: 1'b1,
		default: '0};

	// the serial clock must stay inside the span every flash accepts
	if (SCK_HALF < 1 || SCK_HALF > 255 ||
		SCK_KHZ < `SFB_FLASH_MIN_KHZ ||
		SCK_KHZ > `SFB_FLASH_MAX_KHZ) begin : g_bad_sck // RQ6
		$error("sfb_top serial clock outside flash range");
	end
	if (`SFB_CS_GAP_CYC > 15) begin : g_bad_gap
		$error("sfb_top deselect gap too long for its counter");
	end
	// the read buffer wraps its pointers, so only powers of two fit
	if (FIFO_DEPTH < 2 ||
		(FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
		$error("sfb_top read buffer depth must be a power of two");
	end
	if (LINK_KHZ < 1) begin : g_bad_link
		$error("sfb_top link clock rate must be positive");
	end

	function automatic sfb_kind_t kind_of(sfb_state_t st,
		sfb_op_t op);
		sfb_kind_t k;
		k = K_READ_STATUS_INSTR;
		case (st)
			S_WRITE_ENABLE_INSTR: k = K_WRITE_ENABLE_INSTR;
			S_WRITE_STATUS_INSTR: k = K_WRITE_STATUS_INSTR;
			S_OP: begin
				case (op)
					OP_READ: k = K_READ;
					OP_PROG: k = K_PROG;
					OP_SERASE: k = K_SERASE;
					default: k = K_CERASE;
				endcase
			end
			default: k = K_READ_STATUS_INSTR;
		endcase
		return k;
	endfunction : kind_of

	// index of the last byte of a frame; len is data count minus one
	function automatic logic [16:0] last_of(sfb_kind_t k,
		logic [15:0] len);
		logic [16:0] l;
		l = 17'h00000;
		case (k)
			K_READ_STATUS_INSTR: l = `SFB_IDX_STAT; // RQ2
			K_WRITE_STATUS_INSTR: l = `SFB_LAST_WRITE_STATUS_INSTR; // RQ5
			K_READ: l = `SFB_READ_HDR + {1'b0, len}; // RQ4
			K_PROG: l = `SFB_PROG_HDR + {1'b0, len}; // RQ4
			K_SERASE: l = `SFB_LAST_ADDR; // RQ3
			default: l = 17'h00000;
		endcase
		return l;
	endfunction : last_of

	function automatic logic [7:0] byte_of(sfb_kind_t k,
		logic [16:0] idx, logic [23:0] a, logic [7:0] wd);
		logic [7:0] b;
		b = `SFB_DUMMY;
		if (idx == 17'h00000) begin
			case (k)
				K_WRITE_ENABLE_INSTR: b = `SFB_OPC_WRITE_ENABLE_INSTR; // RQ2
				K_READ_STATUS_INSTR: b = `SFB_OPC_READ_STATUS_INSTR; // RQ2
				K_WRITE_STATUS_INSTR: b = `SFB_OPC_WRITE_STATUS_INSTR; // RQ2
				K_READ: b = `SFB_OPC_READ; // RQ1
				K_PROG: b = `SFB_OPC_PROG; // RQ3
				K_SERASE: b = `SFB_OPC_SERASE; // RQ11
				default: b = `SFB_OPC_CERASE; // RQ3
			endcase
		end else if (k == K_WRITE_STATUS_INSTR) begin
			b = `SFB_ST_CLEAR; // RQ14
		end else if (k == K_READ || k == K_PROG ||
			k == K_SERASE) begin
			// most significant address byte goes out first
			case (idx)
				17'h00001: b = a[23:16]; // RQ1
				17'h00002: b = a[15:8];
				17'h00003: b = a[7:0];
				default: b = (k == K_PROG) ? wd : `SFB_DUMMY;
			endcase
		end
		return b;
	endfunction : byte_of

	sfb_core_t q_r, q_nxt;
	logic done, last_b, data_rd, data_wr;
	logic fifo_push, fifo_in_ready;
	logic ack_t;
	logic [7:0] rx_byte;
	logic pin_oe;

	always_comb begin
		q_nxt = q_r;
		q_nxt.ack1 = ack_t;
		q_nxt.ack2 = q_r.ack1;
		done = q_r.inflight && (q_r.ack2 == q_r.req_t);
		last_b = q_r.idx == q_r.last;
		data_rd = q_r.kind == K_READ && q_r.idx >= `SFB_READ_HDR;
		data_wr = q_r.kind == K_PROG && q_r.idx >= `SFB_PROG_HDR;
		fifo_push = 1'b0;
		cmd_ready = 1'b0;
		wr_ready = q_r.fr_on && !q_r.inflight && data_wr;
		if (q_r.gap != 4'h0)
			q_nxt.gap = q_r.gap - 4'h1;
		if (done) begin
			q_nxt.inflight = 1'b0;
			q_nxt.idx = q_r.idx + 17'h00001;
			if (q_r.kind == K_READ_STATUS_INSTR && q_r.idx == `SFB_IDX_STAT)
				q_nxt.status = rx_byte; // RQ2
			// room was checked when the byte went out
			fifo_push = data_rd; // RQ1
			if (last_b) begin
				q_nxt.fr_on = 1'b0;
				q_nxt.gap = GAP; // RQ16
				case (q_r.st)
					S_WRITE_ENABLE_INSTR: q_nxt.st = S_WEL;
					S_WEL: begin
						if (rx_byte[`SFB_ST_WEL]) // RQ13
							q_nxt.st = q_r.boot ? S_WRITE_STATUS_INSTR : S_OP;
					end
					S_WRITE_STATUS_INSTR: q_nxt.st = S_WIP; // RQ14
					S_OP: begin
						if (q_r.kind == K_READ)
							q_nxt.st = S_IDLE;
						else
							q_nxt.st = S_WIP; // RQ17
					end
					S_WIP: begin
						if (!rx_byte[`SFB_ST_WIP]) begin // RQ17
							q_nxt.st = S_IDLE;
							if (q_r.boot) begin
								q_nxt.boot = 1'b0;
								q_nxt.boot_done = 1'b1;
							end
						end
					end
					default: q_nxt.st = S_IDLE;
				endcase
			end
		end else if (q_r.fr_on && !q_r.inflight) begin
			// a full buffer or a missing data byte pauses the clock
			if ((!data_rd || fifo_in_ready) &&
				(!data_wr || wr_valid)) begin // RQ4
				q_nxt.tx = byte_of(q_r.kind, q_r.idx, q_r.addr,
					wr_data);
				q_nxt.fin = last_b; // RQ16
				q_nxt.req_t = !q_r.req_t;
				q_nxt.inflight = 1'b1;
			end
		end else if (!q_r.fr_on && q_r.gap == 4'h0) begin
			if (q_r.st == S_IDLE) begin
				cmd_ready = 1'b1;
				if (cmd_valid) begin // RQ10
					q_nxt.op = cmd_op;
					q_nxt.addr = cmd_addr;
					q_nxt.len = cmd_len;
					// latch is gone after every op, so ask again
					q_nxt.st = (cmd_op == OP_READ) ?
						S_OP : S_WRITE_ENABLE_INSTR; // RQ15
				end
			end else begin
				q_nxt.fr_on = 1'b1;
				q_nxt.idx = 17'h00000;
				q_nxt.kind = kind_of(q_r.st, q_r.op);
				q_nxt.last = last_of(kind_of(q_r.st, q_r.op),
					q_r.len);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			q_r <= CORE_RST;
		else
			q_r <= q_nxt;
	end

	sfb_fifo #(
		.W(`SFB_FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(rx_byte),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	sfb_shift #(
		.SCK_HALF(SCK_HALF)
	) u_shift (
		.link_clk(link_clk),
		.rst_n(rst_n),
		.req_t(q_r.req_t),
		.tx_byte(q_r.tx),
		.tx_last(q_r.fin),
		.ack_t(ack_t),
		.rx_byte(rx_byte),
		.sck(flash_serial_clock),
		.mosi(flash_serial_out),
		.csn(flash_select_primary_n),
		.pin_oe(pin_oe),
		.miso(flash_serial_in)
	);

	// one enable for the three primary pins; floats under reset
	assign flash_serial_clock_oe = pin_oe; // RQ8
	assign flash_serial_out_oe = pin_oe; // RQ8
	assign flash_select_primary_oe = pin_oe; // RQ8
	// secondary select is never released by reset
	assign flash_select_secondary_n = 1'b1; // RQ9
	// no hold or write-protect outputs exist; pull-ups keep them off
	// RQ7
	assign busy = q_r.st != S_IDLE;
	assign boot_done = q_r.boot_done;
	assign flash_status = q_r.status;
endmodule : sfb_top
`default_nettype wire

/* hw/sfb_defs.svh */
// sfb_defs.svh: constants of the serial flash boot command master
// assumes a 25 MHz core clock and one single-bit, mode 0 NOR flash
// Overview of operation
// RQ1 - fast read: 0B, three address, dummy, data
// RQ2 - write enable 06, status read 05, write 01
// RQ3 - program 02, sector erase 20, chip C7
// RQ4 - read and program data run on freely
// RQ5 - status write carries one status byte only
// RQ6 - flash accepts 1.4 to 30.1 MHz clock
// RQ7 - hold and write-protect pins never driven
// RQ8 - reset low floats clock, data, primary select
// RQ9 - secondary select unaffected by reset
// RQ10 - running controller can program flash itself
// RQ11 - flash erases in 4 KB sectors
// RQ12 - single-bit transfers, clock mode 0 only
// RQ13 - write enable, poll latch, then program/erase
// RQ14 - boot clears all status protection bits
// RQ15 - flash drops write enable after each op
// RQ16 - select low for whole command, high between
// RQ17 - poll busy bit clear after program/erase
`ifndef SFB_DEFS_SVH
`define SFB_DEFS_SVH
`define SFB_OPC_READ 8'h0B
`define SFB_OPC_WRITE_ENABLE_INSTR 8'h06
`define SFB_OPC_READ_STATUS_INSTR 8'h05
`define SFB_OPC_WRITE_STATUS_INSTR 8'h01
`define SFB_OPC_PROG 8'h02
`define SFB_OPC_SERASE 8'h20
`define SFB_OPC_CERASE 8'hC7
`define SFB_ST_WIP 0
`define SFB_ST_WEL 1
`define SFB_ST_CLEAR 8'h00
`define SFB_DUMMY 8'h00
`define SFB_IDX_STAT 17'h00003
`define SFB_LAST_WRITE_STATUS_INSTR 17'h00001
`define SFB_LAST_ADDR 17'h00003
`define SFB_PROG_HDR 17'h00004
`define SFB_READ_HDR 17'h00005
`define SFB_CORE_MHZ 25
`define SFB_CS_GAP_NS 200
`define SFB_CS_GAP_CYC ((`SFB_CS_GAP_NS * `SFB_CORE_MHZ + 999) / 1000)
`define SFB_FLASH_MIN_KHZ 1400
`define SFB_FLASH_MAX_KHZ 30100
`define SFB_LINK_KHZ 83333
`define SFB_SCK_HALF 2
`define SFB_FIFO_DEPTH 16
`define SFB_FIFO_W 8
`endif

/* hw/sfb_pkg.sv */
// sfb_pkg: types shared by the flash command master
// assumes sfb_defs.svh sits on the include path
package sfb_pkg;
	typedef enum logic [1:0] {
		OP_READ, OP_PROG, OP_SERASE, OP_CERASE
	} sfb_op_t;
	typedef enum logic [2:0] {
		K_WRITE_ENABLE_INSTR, K_READ_STATUS_INSTR, K_WRITE_STATUS_INSTR, K_READ, K_PROG, K_SERASE, K_CERASE
	} sfb_kind_t;
	typedef enum logic [2:0] {
		S_WRITE_ENABLE_INSTR, S_WEL, S_WRITE_STATUS_INSTR, S_OP, S_WIP, S_IDLE
	} sfb_state_t;
	typedef struct packed {
		sfb_state_t st;
		sfb_kind_t kind;
		sfb_op_t op;
		logic boot;
		logic boot_done;
		logic fr_on;
		logic [16:0] idx;
		logic [16:0] last;
		logic [23:0] addr;
		logic [15:0] len;
		logic req_t;
		logic inflight;
		logic [7:0] tx;
		logic fin;
		logic ack1;
		logic ack2;
		logic [3:0] gap;
		logic [7:0] status;
	} sfb_core_t;
	typedef struct packed {
		logic rs1, rs2, rq1, rq2, rq3, mi1, mi2;
		logic oe, sck, csn, mosi, busy, fin, ack_t;
		logic [3:0] bitn;
		logic [7:0] div;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [1:0] samp;
	} sfb_link_t;
endpackage : sfb_pkg

/* hw/sfb_fifo.sv */
// sfb_fifo: read-data buffer, memory plus a registered output word
// assumes one clock; in_ready falls only when the memory is full
`timescale 1ns/10ps
`default_nettype none
module sfb_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} sfb_fifo_st_t;
	sfb_fifo_st_t q_r, q_nxt;
	logic push, load;
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sfb_fifo depth must be a power of two");
	end
	always_comb begin
		q_nxt = q_r;
		in_ready = q_r.cnt != (AW+1)'(DEPTH);
		push = in_valid && in_ready;
		load = (!q_r.ov || out_ready) && q_r.cnt != '0;
		if (push) begin
			q_nxt.mem[q_r.wp] = in_data;
			q_nxt.wp = q_r.wp + 1'b1;
		end
		if (load) begin
			q_nxt.od = q_r.mem[q_r.rp];
			q_nxt.ov = 1'b1;
			q_nxt.rp = q_r.rp + 1'b1;
		end else if (out_ready) begin
			q_nxt.ov = 1'b0;
		end
		if (push && !load)
			q_nxt.cnt = q_r.cnt + 1'b1;
		else if (load && !push)
			q_nxt.cnt = q_r.cnt - 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end
	assign out_valid = q_r.ov;
	assign out_data = q_r.od;
endmodule : sfb_fifo
`default_nettype wire

/* hw/sfb_shift.sv */
// sfb_shift: link-side byte shifter, runs on the link clock
// assumes tx_byte and tx_last stay put while req_t is unanswered
`timescale 1ns/10ps
`default_nettype none
module sfb_shift #(
	parameter int SCK_HALF = 2
) (
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic req_t,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	output logic ack_t,
	output logic [7:0] rx_byte,
	output logic sck,
	output logic mosi,
	output logic csn,
	output logic pin_oe,
	input wire logic miso
);
	import sfb_pkg::*;
	localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
	localparam sfb_link_t LINK_RST = '{csn: 1'b1, default: '0};
	sfb_link_t q_r, q_nxt;
	logic tick;
	always_comb begin
		q_nxt = q_r;
		q_nxt.rs1 = rst_n;
		q_nxt.rs2 = q_r.rs1;
		q_nxt.rq1 = req_t;
		q_nxt.rq2 = q_r.rq1;
		q_nxt.rq3 = q_r.rq2;
		q_nxt.mi1 = miso;
		q_nxt.mi2 = q_r.mi1;
		q_nxt.samp = {q_r.samp[0], 1'b0};
		q_nxt.oe = 1'b1;
		tick = q_r.div == 8'h00;
		if (q_r.busy) begin
			q_nxt.div = tick ? HALF_M1 : q_r.div - 8'h01;
			// mode 0: launch on the fall, flash samples on the rise
			if (tick && q_r.sck) begin // RQ12
				q_nxt.sck = 1'b0;
				q_nxt.tx = {q_r.tx[6:0], 1'b0};
				q_nxt.mosi = q_r.tx[6];
			end else if (tick && q_r.bitn != 4'h0) begin
				q_nxt.sck = 1'b1;
				q_nxt.bitn = q_r.bitn - 4'h1;
				q_nxt.samp[0] = 1'b1;
			end
			// input is two stages late, so shift in two cycles on
			if (q_r.samp[1])
				q_nxt.rx = {q_r.rx[6:0], q_r.mi2};
			if (!q_r.sck && q_r.bitn == 4'h0 && q_r.samp == 2'b00) begin
				q_nxt.busy = 1'b0;
				q_nxt.ack_t = !q_r.ack_t;
				if (q_r.fin)
					q_nxt.csn = 1'b1; // RQ16
			end
		end else if (q_r.rq2 != q_r.rq3) begin
			q_nxt.busy = 1'b1;
			q_nxt.csn = 1'b0; // RQ16
			q_nxt.tx = tx_byte;
			q_nxt.mosi = tx_byte[7];
			q_nxt.fin = tx_last;
			q_nxt.bitn = 4'h8;
			q_nxt.div = HALF_M1;
		end
		if (!q_r.rs2) begin
			q_nxt = LINK_RST; // RQ8
			q_nxt.rs1 = rst_n;
			q_nxt.rs2 = q_r.rs1;
			q_nxt.rq1 = req_t;
			q_nxt.mi1 = miso;
			q_nxt.mi2 = q_r.mi1;
		end
	end
	always_ff @(posedge link_clk) begin
		q_r <= q_nxt;
	end
	assign ack_t = q_r.ack_t;
	assign rx_byte = q_r.rx;
	assign sck = q_r.sck;
	assign mosi = q_r.mosi;
	assign csn = q_r.csn;
	assign pin_oe = q_r.oe;
endmodule : sfb_shift
`default_nettype wire

/* tb/sfb_checker.sv */
// sfb_checker: port-level pin and handshake checks for the flash master
// assumes it is bound onto sfb_top and sees nothing but its ports
`timescale 1ns/10ps
`default_nettype none
module sfb_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic wr_ready,
	input wire logic busy,
	input wire logic boot_done,
	input wire logic flash_serial_clock,
	input wire logic flash_serial_clock_oe,
	input wire logic flash_serial_out,
	input wire logic flash_serial_out_oe,
	input wire logic flash_select_primary_n,
	input wire logic flash_select_primary_oe,
	input wire logic flash_select_secondary_n
);
	logic sck_r;
	logic [15:0] bits_r;
	// rising clock edges per frame; a torn byte leaves a remainder
	always_ff @(posedge link_clk) begin
		sck_r <= flash_serial_clock;
		if (flash_select_primary_n) bits_r <= 16'h0000;
		else if (flash_serial_clock && !sck_r) bits_r <= bits_r + 16'h0001;
	end
	a_sel2_steady: assert property (@(posedge core_clk)
		flash_select_secondary_n) else $error("second select moved");
	a_reset_float: assert property (@(posedge link_clk) !rst_n [*5] |->
		!flash_serial_clock_oe && !flash_serial_out_oe &&
		!flash_select_primary_oe) else $error("pins driven in reset");
	a_oe_joint: assert property (@(posedge link_clk) disable iff (!rst_n)
		flash_serial_clock_oe == flash_select_primary_oe &&
		flash_serial_out_oe == flash_select_primary_oe)
		else $error("pin enables differ");
	a_clk_idle_low: assert property (@(posedge link_clk) disable iff (!rst_n)
		flash_select_primary_n |-> !flash_serial_clock)
		else $error("clock high while deselected");
	a_out_steady: assert property (@(posedge link_clk) disable iff (!rst_n)
		flash_serial_clock && $past(flash_serial_clock) |->
		$stable(flash_serial_out)) else $error("data moved on high clock");
	a_whole_bytes: assert property (@(posedge link_clk) disable iff (!rst_n)
		$rose(flash_select_primary_n) |->
		bits_r != 16'h0000 && bits_r[2:0] == 3'h0)
		else $error("frame not whole bytes");
	a_sel_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(flash_select_primary_n) |=> flash_select_primary_n [*5])
		else $error("select high time short");
	a_take_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_valid && cmd_ready |=> busy) else $error("taken, not busy");
	a_ready_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_ready |-> !busy && boot_done) else $error("ready while busy");
	a_wr_in_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_ready |-> busy && !flash_select_primary_n)
		else $error("data taken outside a frame");
endmodule : sfb_checker
bind sfb_top sfb_checker u_sfb_checker (.*);
`default_nettype wire

/* tb/sfb_flash_model.sv */
// sfb_flash_model: behavioural serial NOR flash, mode 0, one data bit
// assumes the bench resolves released pins; erased bytes read FF
`timescale 1ns/10ps
`default_nettype none
module sfb_flash_model (
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] mem [int];
	logic [7:0] ops [$];
	logic [7:0] st = 8'h9C;
	logic [7:0] sh, op, dq, wv;
	int a, bc, nb, wl, wp, slow, wn;
	function automatic logic [7:0] rd(input int x);
		return mem.exists(x) ? mem[x] : 8'hFF;
	endfunction : rd
	// protected or latch-less parts ignore program and erase
	function automatic logic ok();
		return st[1] && st[6:2] == 5'h00;
	endfunction : ok
	initial miso = 1'b0;
	always @(negedge csn) begin
		bc = 0;
		nb = 0;
		dq = 8'h00;
		op = 8'hFF;
	end
	// purely edge driven, so any clock rate is accepted
	always @(negedge sck) if (!csn) miso = dq[7 - nb];
	always @(posedge sck) if (!csn) begin
		sh = {sh[6:0], mosi};
		nb++;
		if (nb == 8) begin
			nb = 0;
			dq = 8'h00;
			if (bc == 0) op = sh;
			else if (bc < 4) a = {a[15:0], sh};
			if (op == 8'h01 && bc == 1) wv = sh;
			if (op == 8'h05 && bc == 2) dq = st;
			if (op == 8'h0B && bc > 3) dq = rd(a + bc - 4);
			if (op == 8'h02 && bc > 3 && ok()) mem[a + bc - 4] = rd(a + bc - 4) & sh;
			bc++;
		end
	end
	always @(posedge csn) begin
		miso = ~miso;
		ops.push_back(op);
		if (op == 8'h01) wn = bc;
		if (op == 8'h01 && st[1]) st[7:2] = wv[7:2];
		if (op == 8'h20 && bc == 4 && ok()) begin
			for (int i = 0; i < 4096; i++) mem.delete((a & 32'hFFF000) + i);
		end
		if (op == 8'hC7 && bc == 1 && ok()) mem.delete();
		if (st[1] && op inside {8'h01, 8'h02, 8'h20, 8'hC7}) begin
			st[1:0] = {1'b0, slow != 0};
			wp = slow;
		end
		if (op == 8'h06 && bc == 1) begin
			st[1] = slow == 0;
			wl = slow;
		end
		if (op == 8'h05 && wl == 1) st[1] = 1'b1;
		if (op == 8'h05 && wp == 1) st[0] = 1'b0;
		if (op == 8'h05 && wl > 0) wl--;
		if (op == 8'h05 && wp > 0) wp--;
	end
endmodule : sfb_flash_model
`default_nettype wire

/* tb/sfb_top_tb.sv */
// sfb_top_tb: self-checking bench for the flash command master
// assumes the flash model on the far side and the bound checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin \
	logic [31:0] e_, s_; \
	e_ = (e); \
	s_ = (s); \
	tests_run++; \
	if (e_ !== s_) begin \
		err_count++; \
		$display("FAIL %s exp %0h got %0h", n, e_, s_); \
	end \
end
module sfb_top_tb;
	import sfb_pkg::*;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic wr_valid = 1'b0;
	logic rd_ready = 1'b0;
	logic hold = 1'b0;
	sfb_op_t cmd_op = OP_READ;
	logic [23:0] cmd_addr = 24'h000000;
	logic [15:0] cmd_len = 16'h0000;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] ex;
	wire cmd_ready, wr_ready, rd_valid, busy, boot_done, flash_serial_in;
	wire [7:0] rd_data, flash_status;
	wire flash_serial_clock, flash_serial_clock_oe, flash_serial_out;
	wire flash_serial_out_oe, flash_select_primary_n;
	wire flash_select_primary_oe, flash_select_secondary_n;
	// released pins: select pulled up, clock and data pulled down
	wire f_sck = flash_serial_clock_oe ? flash_serial_clock : 1'b0;
	wire f_cs = flash_select_primary_oe ? flash_select_primary_n : 1'b1;
	wire f_mo = flash_serial_out_oe ? flash_serial_out : 1'b0;
	int err_count = 0;
	int tests_run = 0;
	int seed = 32'h0A7A;
	int a;
	logic [7:0] mem [int];
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	sfb_top #(.SCK_HALF(2)) u_sfb_top (.*);
	sfb_flash_model u_flash (.sck(f_sck), .csn(f_cs), .mosi(f_mo),
		.miso(flash_serial_in));
	always #20 core_clk = ~core_clk;
	initial begin
		#3.3;
		forever #6 link_clk = ~link_clk;
	end
	function automatic logic [7:0] exp_at(input int x);
		return mem.exists(x) ? mem[x] : 8'hFF;
	endfunction : exp_at
	always @(negedge core_clk) begin
		rd_ready <= !hold && $random(seed) % 2 != 0;
		wr_valid <= wq.size() > 0;
		wr_data <= wq.size() > 0 ? wq[0] : 8'h00;
	end
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) void'(wq.pop_front());
		if (rd_valid && rd_ready) begin
			ex = rq.pop_front();
			`CHK("rd_data", ex, rd_data)
		end
	end
	task automatic close_out();
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	task automatic take(input sfb_op_t o, input int ad, input int n);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = ad[23:0];
		cmd_len = 16'(n - 1);
		do @(posedge core_clk); while (!cmd_ready);
		@(negedge core_clk);
		cmd_valid = 1'b0;
	endtask : take
	task automatic done();
		do @(posedge core_clk); while (!cmd_ready || rq.size() != 0);
	endtask : done
	task automatic seq(input logic [7:0] c);
		logic [7:0] x;
		`CHK("write_enable_instr", 8'h06, u_flash.ops.pop_front())
		x = u_flash.ops.pop_front();
		while (x == 8'h05) x = u_flash.ops.pop_front();
		`CHK("opcode", c, x)
		`CHK("wip poll", 8'h05, u_flash.ops.pop_back())
		`CHK("wip bit", 1'b0, flash_status[0])
		u_flash.ops.delete();
	endtask : seq
	task automatic prog(input int ad, input int n);
		logic [7:0] b;
		take(OP_PROG, ad, n);
		// data held back 40 cycles, still queued before the program frame starts
		repeat (40) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			b = 8'($random(seed));
			wq.push_back(b);
			mem[ad + i] = exp_at(ad + i) & b;
		end
		done();
		seq(8'h02);
	endtask : prog
	task automatic rdchk(input int ad, input int n, input int stall);
		for (int i = 0; i < n; i++) rq.push_back(exp_at(ad + i));
		hold = stall != 0;
		take(OP_READ, ad, n);
		repeat (stall) @(posedge core_clk);
		if (stall != 0) begin
			`CHK("stalled busy", 1'b1, busy)
			`CHK("stalled valid", 1'b1, rd_valid)
		end
		hold = 1'b0;
		done();
		`CHK("read op", 8'h0B, u_flash.ops.pop_front())
		u_flash.ops.delete();
	endtask : rdchk
	initial begin
		repeat (60000) @(posedge core_clk);
		err_count++;
		close_out();
	end
	initial begin
		u_flash.slow = 2;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		// power-up leaves the select unknown; its rise to the pull-up
		// level is not a frame, so forget what the flash logged
		u_flash.ops.delete();
		rst_n = 1'b1;
		done();
		`CHK("boot done", 1'b1, boot_done)
		`CHK("status", 8'h00, u_flash.st)
		`CHK("write_status_instr bytes", 2, u_flash.wn)
		seq(8'h01);
		a = 32'h012300 + ($random(seed) & 32'hF0);
		prog(a, 8);
		u_flash.slow = 0;
		prog(a + 4096, 5);
		rdchk(a, 24, 800);
		take(OP_SERASE, a, 1);
		done();
		for (int i = 0; i < 4096; i++) mem.delete((a & 32'hFFF000) + i);
		seq(8'h20);
		rdchk(a - 2, 6, 0);
		rdchk(a + 4094, 8, 0);
		u_flash.slow = 3;
		take(OP_PROG, a, 4);
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b0;
		repeat (5) @(posedge core_clk);
		`CHK("pins oe", 1'b0, flash_serial_clock_oe)
		`CHK("sel2", 1'b1, flash_select_secondary_n)
		@(negedge core_clk);
		rst_n = 1'b1;
		done();
		u_flash.ops.delete();
		take(OP_CERASE, 0, 1);
		done();
		mem.delete();
		seq(8'hC7);
		rdchk(a + 4096, 5, 0);
		close_out();
	end
endmodule : sfb_top_tb
`default_nettype wire
